// ===== fifo_ctrl_pkg.sv
// constants for the host fifo receive/transmit control block
package fifo_ctrl_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  RECEIVE_CONFIG_OFS  = 8'h6C;
   localparam logic [7:0]  TRANSMIT_CONFIG_OFS = 8'h70;
   localparam logic [31:0] RECEIVE_CONFIG_RST  = 32'h0000_0000;
   localparam logic [31:0] TRANSMIT_CONFIG_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // receive_config fields
   // ----------------------------------------------------------------
   localparam int RX_ALIGN_LSB     = 30;
   localparam int RX_ALIGN_W       = 2;
   localparam int RX_COUNT_LSB     = 16;
   localparam int RX_COUNT_W       = 12;
   localparam int RX_DISCARD_BIT   = 15;
   localparam int RX_OFFSET_LSB    = 8;
   localparam int RX_OFFSET_W      = 5;

   // ----------------------------------------------------------------
   // transmit_config fields
   // ----------------------------------------------------------------
   localparam int TX_STATUS_DISCARD_BIT = 15;
   localparam int TX_DATA_DISCARD_BIT   = 14;
   localparam int TX_ALLOW_OVERRUN_BIT  = 2;
   localparam int TX_ENABLE_BIT         = 1;
   localparam int TX_STOP_BIT           = 0;

   // ----------------------------------------------------------------
   // end alignment codes and the dword mask each selects
   // ----------------------------------------------------------------
   localparam logic [1:0] ALIGN_4B   = 2'h0;
   localparam logic [1:0] ALIGN_16B  = 2'h1;
   localparam logic [1:0] ALIGN_32B  = 2'h2;
   localparam logic [1:0] ALIGN_RSVD = 2'h3;
   localparam logic [2:0] MASK_4B    = 3'h0;
   localparam logic [2:0] MASK_16B   = 3'h3;
   localparam logic [2:0] MASK_32B   = 3'h7;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_LEAD,
      RX_DATA,
      RX_TAIL
   } rx_state_t;

endpackage : fifo_ctrl_pkg

// ===== fifo_side_model.sv
// model of the receive fifo and transmitter facing the control block
`timescale 1ns/100ps
`default_nettype none
module fifo_side_model #(
   parameter int FRAME_LEN = 15
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // bench commands
   input  wire logic       load,
   input  wire logic [3:0] words,
   input  wire logic       frame_req,
   // from the block
   input  wire logic       rx_fifo_pop,
   input  wire logic       rx_discard,
   input  wire logic       tx_run,
   // to the block
   output logic            rx_pkt_ready,
   output logic            rx_data_last,
   output logic            tx_frame_active
);
   logic [3:0] words_q;
   logic [4:0] len_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) words_q <= 4'h0;
      else if (load) words_q <= words;
      else if (rx_discard) words_q <= 4'h0;
      else if (rx_fifo_pop && words_q != 4'h0) words_q <= words_q - 4'h1;
   end
   assign rx_pkt_ready = words_q != 4'h0;
   assign rx_data_last = words_q == 4'h1;
   // a frame once begun runs to its end, as on the wire
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) len_q <= 5'h0;
      else if (len_q != 5'h0) len_q <= len_q - 5'h1;
      else if (frame_req && tx_run) len_q <= 5'(FRAME_LEN);
   end
   assign tx_frame_active = len_q != 5'h0;
endmodule : fifo_side_model
`default_nettype wire

// ===== host_fifo_chk.sv
// port assertions for the host fifo control block
`timescale 1ns/100ps
`default_nettype none
module host_fifo_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // host bus
   input wire logic        cs_n,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   // fifo and transmit side
   input wire logic        rx_dword_rd,
   input wire logic        rx_fifo_pop,
   input wire logic        rx_fill_sel,
   input wire logic        rx_buf_done,
   input wire logic        rx_discard,
   input wire logic        rx_dma_int_en,
   input wire logic        rx_dma_event,
   input wire logic        rx_dma_irq,
   input wire logic        tx_frame_active,
   input wire logic        tx_status_full,
   input wire logic        tx_run,
   input wire logic        tx_stopped,
   input wire logic        tx_status_full_event,
   input wire logic        tx_status_discard,
   input wire logic        tx_data_discard
);
   localparam logic [7:0] RXA = fifo_ctrl_pkg::RECEIVE_CONFIG_OFS;
   localparam logic [7:0] TXA = fifo_ctrl_pkg::TRANSMIT_CONFIG_OFS;
   logic idle_q, allow_q, wr_go, rd_go;
   // a write counts once per strobe, on its first low edge
   assign wr_go = !cs_n && !wr_n && idle_q;
   assign rd_go = !cs_n && !rd_n;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) idle_q <= 1'b1;
      else idle_q <= wr_n | cs_n;
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) allow_q <= 1'b0;
      else if (wr_go && addr == TXA) allow_q <= wdata[2];
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_rx_discard; wr_go && addr == RXA && wdata[15] |=> rx_discard; endproperty
   a_rx_discard: assert property (p_rx_discard) else $error("rx discard pulse missing");
   property p_ts_discard; wr_go && addr == TXA && wdata[15] |=> tx_status_discard; endproperty
   a_ts_discard: assert property (p_ts_discard) else $error("status discard missing");
   property p_td_discard; wr_go && addr == TXA && wdata[14] |=> tx_data_discard; endproperty
   a_td_discard: assert property (p_td_discard) else $error("data discard missing");
   property p_overrun; tx_run && tx_status_full |-> allow_q; endproperty
   a_overrun: assert property (p_overrun) else $error("sending into full status");
   property p_full_event; $rose(tx_status_full) |-> tx_status_full_event; endproperty
   a_full_event: assert property (p_full_event) else $error("status full event missing");
   property p_irq_gate; rx_dma_irq |-> rx_dma_int_en; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq while masked");
   property p_stop; tx_stopped |-> !tx_run && !$past(tx_frame_active); endproperty
   a_stop: assert property (p_stop) else $error("stop during frame");
   property p_buf_done; rx_buf_done |-> $past(rx_dword_rd); endproperty
   a_buf_done: assert property (p_buf_done) else $error("buffer end without read");
   property p_pop; rx_fifo_pop |-> rx_dword_rd && !rx_fill_sel; endproperty
   a_pop: assert property (p_pop) else $error("pop on fill word");
   property p_dma_event; rx_dma_event |-> $past(rx_dword_rd) || $past(rx_dword_rd, 2); endproperty
   a_dma_event: assert property (p_dma_event) else $error("count event without read");
   property p_rd_zero; rdata != 32'h0 |-> $past(rd_go && (addr == RXA || addr == TXA)); endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data without read");
   property p_rsvd; $past(rd_go) && $past(addr) == TXA |-> (rdata & 32'hFFFF_3FF8) == 32'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
   c_stop: cover property (tx_stopped);
   c_buf: cover property (rx_buf_done);
   c_irq: cover property (rx_dma_irq);
endmodule : host_fifo_chk
bind host_fifo_rx_tx_control host_fifo_chk i_host_fifo_chk (.*);
`default_nettype wire

// ===== host_fifo_rx_tx_control.sv
// receive and transmit configuration control for the host fifos
// What this block does
// R01: pad last buffer transfer up to chosen alignment
// R02: alignment codes 4, 16, 32 bytes; 11 reserved
// R03: host sets alignment only between packets
// R04: 12-bit dword count, decrement, raise event
// R05: new count write accepted, counting restarts
// R06: receive discard clears rx pointers, self-clears
// R07: insert 0-31 byte offset before packet data
// R08: host changes low offset bits only halted
// R09: dword offset applies from next dword read
// R10: tx status discard clears pointers, self-clears
// R11: tx data discard clears pointers, self-clears
// R12: status full suspends transmit unless overrun allowed
// R13: status full event independent of overrun bit
// R14: transmitter enabled sends queued fifo data
// R15: enable clears itself after stop completes
// R16: stop finishes current frame, then self-clears
// R17: writes to stop ignored while it reads one
// R18: dma interrupt gated by its enable bit
// R19: reserved read zero, fields reset zero
`timescale 1ns/100ps
`default_nettype none
module host_fifo_rx_tx_control (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // host register port, sram-like, active-low strobes
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   output logic      [31:0] rdata,
   // receive data fifo side
   input  wire logic        rx_pkt_ready,
   input  wire logic        rx_data_last,
   input  wire logic        rx_dword_rd,
   output logic             rx_fifo_pop,
   output logic             rx_fill_sel,
   output logic      [1:0]  rx_byte_shift,
   output logic             rx_buf_done,
   output logic             rx_discard,
   // receive dma interrupt
   input  wire logic        rx_dma_int_en,
   input  wire logic        rx_dma_flag_clr,
   output logic             rx_dma_event,
   output logic             rx_dma_irq,
   // transmit side
   input  wire logic        tx_frame_active,
   input  wire logic        tx_status_full,
   output logic             tx_run,
   output logic             tx_stopped,
   output logic             tx_status_full_event,
   output logic             tx_status_discard,
   output logic             tx_data_discard
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // host strobe decode
   // ----------------------------------------------------------------
   logic wr_n_q;
   logic wr_take;
   logic rd_take;
   logic sel_rx;
   logic sel_tx;

   // a write is taken once, on the cycle its strobe falls
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_n_q <= 1'b1;
      end else begin
         wr_n_q <= wr_n | cs_n;
      end
   end

   assign wr_take = !cs_n && !wr_n && wr_n_q;
   assign rd_take = !cs_n && !rd_n;
   assign sel_rx  = (addr == fifo_ctrl_pkg::RECEIVE_CONFIG_OFS);
   assign sel_tx  = (addr == fifo_ctrl_pkg::TRANSMIT_CONFIG_OFS);

   // ----------------------------------------------------------------
   // receive configuration fields
   // ----------------------------------------------------------------
   logic [1:0]  align_q;
   logic [4:0]  offset_q;
   logic        rx_discard_q;
   logic        count_load;
   logic [11:0] count_val;
   logic        count_done;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         align_q  <= '0;                                           // R19
         offset_q <= '0;
      end else if (wr_take && sel_rx) begin
         align_q  <= wdata[fifo_ctrl_pkg::RX_ALIGN_LSB +: fifo_ctrl_pkg::RX_ALIGN_W];
         offset_q <= wdata[fifo_ctrl_pkg::RX_OFFSET_LSB +: fifo_ctrl_pkg::RX_OFFSET_W];
      end
   end

   // discard is a one-cycle strobe, so it reads back as zero afterwards
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_discard_q <= 1'b0;
      end else begin
         rx_discard_q <= wr_take && sel_rx && wdata[fifo_ctrl_pkg::RX_DISCARD_BIT]; // R06
      end
   end

   assign count_load = wr_take && sel_rx;                          // R05

   rx_transfer_counter #(
      .WIDTH      (fifo_ctrl_pkg::RX_COUNT_W)
   ) u_count (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .load       (count_load),
      .load_value (wdata[fifo_ctrl_pkg::RX_COUNT_LSB +: fifo_ctrl_pkg::RX_COUNT_W]),
      .dec        (rx_dword_rd),
      .count      (count_val),
      .done       (count_done)
   );

   logic rx_dma_flag_q;

   // set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_dma_flag_q <= 1'b0;
      end else if (count_done) begin
         rx_dma_flag_q <= 1'b1;                                    // R04
      end else if (rx_dma_flag_clr) begin
         rx_dma_flag_q <= 1'b0;
      end
   end

   assign rx_dma_event = count_done;
   assign rx_dma_irq   = rx_dma_flag_q && rx_dma_int_en;           // R18

   // ----------------------------------------------------------------
   // receive buffer sequencer: lead offset, data, tail padding
   // ----------------------------------------------------------------
   fifo_ctrl_pkg::rx_state_t rx_state_q;
   logic [2:0] lead_q;
   logic [2:0] pos_q;
   logic [2:0] pos_next;
   logic [2:0] align_mask;
   logic       lead_fill;

   always_comb begin
      unique case (align_q)                                        // R02
         fifo_ctrl_pkg::ALIGN_4B:   align_mask = fifo_ctrl_pkg::MASK_4B;
         fifo_ctrl_pkg::ALIGN_16B:  align_mask = fifo_ctrl_pkg::MASK_16B;
         fifo_ctrl_pkg::ALIGN_32B:  align_mask = fifo_ctrl_pkg::MASK_32B;
         fifo_ctrl_pkg::ALIGN_RSVD: align_mask = fifo_ctrl_pkg::MASK_4B;
      endcase
   end

   // the dword part of the offset is read live, so a change lands on
   // the next dword read; the byte part goes straight to the aligner
   assign lead_fill     = (rx_state_q == fifo_ctrl_pkg::RX_LEAD)
                          && (lead_q < offset_q[4:2]);             // R09
   assign pos_next      = pos_q + 3'h1;
   assign rx_fill_sel   = lead_fill || (rx_state_q == fifo_ctrl_pkg::RX_TAIL);
   assign rx_fifo_pop   = rx_dword_rd && !rx_fill_sel
                          && ((rx_state_q == fifo_ctrl_pkg::RX_LEAD)
                          || (rx_state_q == fifo_ctrl_pkg::RX_DATA));
   assign rx_byte_shift = offset_q[1:0];                           // R07

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_q <= fifo_ctrl_pkg::RX_IDLE;
         lead_q     <= '0;
         pos_q      <= '0;
      end else if (rx_discard_q) begin
         rx_state_q <= fifo_ctrl_pkg::RX_IDLE;                     // R06
         lead_q     <= '0;
         pos_q      <= '0;
      end else begin
         unique case (rx_state_q)
            fifo_ctrl_pkg::RX_IDLE: begin
               lead_q <= '0;
               pos_q  <= '0;
               if (rx_pkt_ready) begin
                  rx_state_q <= fifo_ctrl_pkg::RX_LEAD;
               end
            end
            fifo_ctrl_pkg::RX_LEAD: begin
               if (rx_dword_rd) begin
                  pos_q <= pos_next;
                  if (lead_fill) begin
                     lead_q <= lead_q + 3'h1;                      // R07
                  end else if (!rx_data_last) begin
                     rx_state_q <= fifo_ctrl_pkg::RX_DATA;
                  end else if ((pos_next & align_mask) != 3'h0) begin
                     rx_state_q <= fifo_ctrl_pkg::RX_TAIL;         // R01
                  end else begin
                     rx_state_q <= fifo_ctrl_pkg::RX_IDLE;
                  end
               end
            end
            fifo_ctrl_pkg::RX_DATA: begin
               if (rx_dword_rd) begin
                  pos_q <= pos_next;
                  if (rx_data_last) begin
                     if ((pos_next & align_mask) != 3'h0) begin
                        rx_state_q <= fifo_ctrl_pkg::RX_TAIL;      // R01
                     end else begin
                        rx_state_q <= fifo_ctrl_pkg::RX_IDLE;
                     end
                  end
               end
            end
            fifo_ctrl_pkg::RX_TAIL: begin
               if (rx_dword_rd) begin
                  pos_q <= pos_next;
                  if ((pos_next & align_mask) == 3'h0) begin
                     rx_state_q <= fifo_ctrl_pkg::RX_IDLE;         // R01
                  end
               end
            end
         endcase
      end
   end

   // one pulse as the final dword of a buffer, pad included, leaves
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_buf_done <= 1'b0;
      end else begin
         rx_buf_done <= rx_dword_rd && !rx_discard_q
                        && (rx_state_q != fifo_ctrl_pkg::RX_IDLE)
                        && !lead_fill
                        && ((rx_state_q == fifo_ctrl_pkg::RX_TAIL) || rx_data_last)
                        && ((pos_next & align_mask) == 3'h0);
      end
   end

   assign rx_discard = rx_discard_q;

   // ----------------------------------------------------------------
   // transmit configuration fields
   // ----------------------------------------------------------------
   logic allow_overrun_q;
   logic tx_on_q;
   logic stop_q;
   logic tx_sdisc_q;
   logic tx_ddisc_q;
   logic tx_halt;

   // halted once no frame is in flight after a stop request
   assign tx_halt = stop_q && !tx_frame_active;                    // R16

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         allow_overrun_q <= 1'b0;
      end else if (wr_take && sel_tx) begin
         allow_overrun_q <= wdata[fifo_ctrl_pkg::TX_ALLOW_OVERRUN_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_on_q <= 1'b0;
      end else if (tx_halt) begin
         tx_on_q <= 1'b0;                                          // R15
      end else if (wr_take && sel_tx) begin
         tx_on_q <= wdata[fifo_ctrl_pkg::TX_ENABLE_BIT];
      end
   end

   // writes while the stop bit is still high leave the stop bit unchanged
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_q <= 1'b0;
      end else if (tx_halt) begin
         stop_q <= 1'b0;                                           // R16
      end else if (wr_take && sel_tx && !stop_q) begin
         stop_q <= wdata[fifo_ctrl_pkg::TX_STOP_BIT];              // R17
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sdisc_q <= 1'b0;
         tx_ddisc_q <= 1'b0;
      end else begin
         tx_sdisc_q <= wr_take && sel_tx && wdata[fifo_ctrl_pkg::TX_STATUS_DISCARD_BIT]; // R10
         tx_ddisc_q <= wdata[fifo_ctrl_pkg::TX_DATA_DISCARD_BIT] && wr_take && sel_tx;   // R11
      end
   end

   logic status_full_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_full_q <= 1'b0;
      end else begin
         status_full_q <= tx_status_full;
      end
   end

   // a stopping transmitter still finishes its frame
   assign tx_run = tx_on_q && !tx_halt && (allow_overrun_q || !tx_status_full); // R12 R14
   assign tx_status_full_event = tx_status_full && !status_full_q; // R13
   assign tx_status_discard    = tx_sdisc_q;
   assign tx_data_discard      = tx_ddisc_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_stopped <= 1'b0;
      end else begin
         tx_stopped <= tx_halt;
      end
   end

   // ----------------------------------------------------------------
   // read-back
   // ----------------------------------------------------------------
   logic [31:0] rx_word;
   logic [31:0] tx_word;

   always_comb begin
      rx_word = fifo_ctrl_pkg::RECEIVE_CONFIG_RST;                 // R19
      rx_word[fifo_ctrl_pkg::RX_ALIGN_LSB +: fifo_ctrl_pkg::RX_ALIGN_W]   = align_q;
      rx_word[fifo_ctrl_pkg::RX_COUNT_LSB +: fifo_ctrl_pkg::RX_COUNT_W]   = count_val;
      rx_word[fifo_ctrl_pkg::RX_OFFSET_LSB +: fifo_ctrl_pkg::RX_OFFSET_W] = offset_q;
   end

   always_comb begin
      tx_word = fifo_ctrl_pkg::TRANSMIT_CONFIG_RST;                // R19
      tx_word[fifo_ctrl_pkg::TX_ALLOW_OVERRUN_BIT] = allow_overrun_q;
      tx_word[fifo_ctrl_pkg::TX_ENABLE_BIT]        = tx_on_q;
      tx_word[fifo_ctrl_pkg::TX_STOP_BIT]          = stop_q;
   end

   // unmapped addresses read as zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd_take && sel_rx) begin
         rdata <= rx_word;
      end else if (rd_take && sel_tx) begin
         rdata <= tx_word;
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

endmodule : host_fifo_rx_tx_control

`default_nettype wire

// ===== host_fifo_rx_tx_control_test.sv
// self-checking testbench for the host fifo control block
`timescale 1ns/100ps
`default_nettype none
module host_fifo_rx_tx_control_test;
   logic        sys_clk, resetn, cs_n, rd_n, wr_n, rx_pkt_ready, rx_data_last, rx_dword_rd;
   logic        rx_fifo_pop, rx_fill_sel, rx_buf_done, rx_discard, rx_dma_int_en;
   logic        rx_dma_flag_clr, rx_dma_event, rx_dma_irq, tx_frame_active, tx_status_full;
   logic        tx_run, tx_stopped, tx_status_full_event, tx_status_discard, tx_data_discard;
   logic        load, frame_req;
   logic [1:0]  rx_byte_shift, code;
   logic [3:0]  words;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   int          errors, checks_done, cycles, events, n, total;
   localparam logic [7:0] RXA = fifo_ctrl_pkg::RECEIVE_CONFIG_OFS;
   localparam logic [7:0] TXA = fifo_ctrl_pkg::TRANSMIT_CONFIG_OFS;

   host_fifo_rx_tx_control i_host_fifo_rx_tx_control (.*);
   fifo_side_model #(.FRAME_LEN(15)) i_fifo_side_model (
      .sys_clk, .rst_n(resetn), .load, .words, .frame_req, .rx_fifo_pop, .rx_discard,
      .tx_run, .rx_pkt_ready, .rx_data_last, .tx_frame_active
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      addr = a;
      wdata = d;
      @(negedge sys_clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
   endtask : bus_write
   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      @(negedge sys_clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      addr = a;
      @(negedge sys_clk);
      d = rdata;
      cs_n = 1'b1;
      rd_n = 1'b1;
   endtask : bus_read
   task automatic print_verdict;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // bound on the whole run, about a hundred cycles expected
   always @(posedge sys_clk) begin
      cycles++;
      if (rx_dma_event === 1'b1) events++;
      if (cycles == 2000) begin
         errors++;
         print_verdict();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {resetn, rd_n, wr_n, cs_n} = 4'h7;
      resetn = 1'b0;
      {addr, wdata, words} = 44'h0;
      {rx_dword_rd, rx_dma_int_en, rx_dma_flag_clr, tx_status_full, load, frame_req} = 6'h0;
      {errors, checks_done, cycles, events} = 128'h0;
      repeat (2) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (3) @(negedge sys_clk);
      bus_read(RXA, v);
      check(v, fifo_ctrl_pkg::RECEIVE_CONFIG_RST);
      bus_read(TXA, v);
      check(v, fifo_ctrl_pkg::TRANSMIT_CONFIG_RST);
      bus_write(8'h74, 32'hFFFF_FFFF);
      bus_read(8'h74, v);
      check(v, 32'h0);
      bus_write(RXA, 32'hFFFF_FFFF);
      check({30'h0, rx_byte_shift}, 32'h3);
      bus_read(RXA, v);
      check(v, 32'hCFFF_1F00);
      bus_write(RXA, 32'h0000_8000);
      bus_read(RXA, v);
      check(v, 32'h0);
      bus_write(TXA, 32'hFFFF_C006);
      bus_read(TXA, v);
      check(v, 32'h0000_0006);
      check({31'h0, tx_run}, 32'h1);
      tx_status_full = 1'b1;
      @(negedge sys_clk);
      check({31'h0, tx_run}, 32'h1);
      bus_write(TXA, 32'h0000_0002);
      check({31'h0, tx_run}, 32'h0);
      tx_status_full = 1'b0;
      @(negedge sys_clk);
      check({31'h0, tx_run}, 32'h1);
      frame_req = 1'b1;
      repeat (2) @(negedge sys_clk);
      frame_req = 1'b0;
      bus_write(TXA, 32'h0000_0003);
      bus_write(TXA, 32'h0000_0002);
      bus_read(TXA, v);
      check(v, 32'h0000_0003);
      check({31'h0, tx_run}, 32'h1);
      n = 0;
      while (tx_stopped !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      check({31'h0, tx_stopped}, 32'h1);
      check({31'h0, tx_run}, 32'h0);
      bus_read(TXA, v);
      check(v, 32'h0);
      // every alignment code, one leading fill dword, two data dwords
      for (int c = 0; c < 4; c++) begin
         code = c[1:0];
         total = (code == 2'h1) ? 4 : (code == 2'h2) ? 8 : 3;
         rx_dma_int_en = code != 2'h2;
         bus_write(RXA, {code, 2'h0, 12'(total), 8'h04, 8'h00});
         load = 1'b1;
         words = 4'h2;
         @(negedge sys_clk);
         load = 1'b0;
         repeat (2) @(negedge sys_clk);
         n = 0;
         rx_dword_rd = 1'b1;
         do begin
            #1;
            if (n < 2) check({31'h0, rx_fill_sel}, {31'h0, n == 0});
            @(negedge sys_clk);
            n++;
         end while (rx_buf_done !== 1'b1 && n < 16);
         rx_dword_rd = 1'b0;
         check(32'(n), 32'(total));
         repeat (2) @(negedge sys_clk);
         check(32'(events), 32'(c + 1));
         check({31'h0, rx_dma_irq}, {31'h0, code != 2'h2});
         rx_dma_flag_clr = 1'b1;
         @(negedge sys_clk);
         rx_dma_flag_clr = 1'b0;
         check({31'h0, rx_dma_irq}, 32'h0);
         bus_read(RXA, v);
         check(v, {code, 2'h0, 12'h0, 8'h04, 8'h00});
      end
      print_verdict();
   end
endmodule : host_fifo_rx_tx_control_test
`default_nettype wire

// ===== rx_transfer_counter.sv
// down-counter of receive dwords with a completion event
`timescale 1ns/100ps
`default_nettype none

module rx_transfer_counter #(
   parameter int WIDTH = 12
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // load and count
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   input  wire logic             dec,
   // state
   output logic      [WIDTH-1:0] count,
   output logic                  done
);

   logic [WIDTH-1:0] count_q;
   logic             done_q;

   // ----------------------------------------------------------------
   // count
   // ----------------------------------------------------------------
   // a new load wins over a decrement in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (load) begin
         count_q <= load_value;                                    // R05
      end else if (dec && (count_q != '0)) begin
         count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};           // R04
      end
   end

   // ----------------------------------------------------------------
   // completion pulse when the last programmed dword leaves
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= !load && dec && (count_q == {{(WIDTH-1){1'b0}}, 1'b1}); // R04
      end
   end

   assign count = count_q;
   assign done  = done_q;

endmodule : rx_transfer_counter

`default_nettype wire
